// ==== core/dcbs_pkg.sv ====
// Shared constants, types and register layout of the DMA channel bus sequencer
package dcbs_pkg;

  localparam int NCH = 4;
  localparam int NPIN = 2;

  // Register address map: channel registers at {1'b0, channel, sub}, status above them
  localparam logic [4:0] ADDR_STATUS = 5'h10;
  localparam logic [1:0] SUB_CTRL = 2'h0;
  localparam logic [1:0] SUB_COUNT = 2'h1;
  localparam logic [1:0] SUB_BLOCK = 2'h2;

  // Activation source encodings
  localparam logic [1:0] SRC_PERIPH = 2'h0;
  localparam logic [1:0] SRC_EDGE = 2'h1;
  localparam logic [1:0] SRC_LEVEL = 2'h2;
  localparam logic [1:0] SRC_AUTO = 2'h3;

  // Least number of states between a request on the pin and the first transfer cycle
  localparam logic [2:0] PIN_MIN_STATES = 3'h4;
  localparam logic [2:0] DLY_ONE = 3'h1;

  localparam logic [15:0] COUNT_ONE = 16'h0001;
  localparam logic [7:0] BLK_ONE = 8'h01;
  localparam logic [15:0] RDATA_ZERO = 16'h0000;

  typedef enum logic [2:0] {
    S_IDLE,
    S_REQ,
    S_DEAD,
    S_READ,
    S_WRITE,
    S_REL
  } dcbs_state_e;

  // Channel control register, bit 0 upward: xfer_enable, master_enable, end_irq_enable,
  // source, burst, block, full (full is honoured on the A channel of a pair)
  typedef struct packed {
    logic full;
    logic block;
    logic burst;
    logic [1:0] src;
    logic end_irq_enable;
    logic master_enable;
    logic xfer_enable;
  } dcbs_ctrl_s;

  typedef struct packed {
    dcbs_ctrl_s ctrl;
    logic [15:0] count;
    logic [7:0] blk_init;
    logic [7:0] blk_cnt;
    logic pend;
  } dcbs_chan_s;

  localparam dcbs_chan_s CHAN_RESET = '0;

  // Bus cycle indication towards the bus controller
  typedef struct packed {
    logic dead;
    logic rd;
    logic wr;
    logic [1:0] chan;
  } dcbs_cyc_s;

  localparam dcbs_cyc_s CYC_IDLE = '0;

endpackage

// ==== core/dcbs_top.sv ====
// DMA channel bus sequencer: arbitration, bus ownership, request sampling and end interrupts
`timescale 1ns/10ps

module dcbs_top (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [4:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic [3:0] periph_req,
  input wire logic [1:0] dma_request_n,
  input wire logic ext_bus_request_n,
  input wire logic refresh_req,
  input wire logic nmi,
  input wire logic standby,
  input wire logic bus_grant,
  input wire logic cyc_done,
  output logic bus_req,
  output dcbs_pkg::dcbs_cyc_s cyc,
  output logic [1:0] transfer_end_n,
  output logic end_irq_ch0a,
  output logic end_irq_ch0b,
  output logic end_irq_ch1a,
  output logic end_irq_ch1b
);

  ////////////////////////////////////////////////////////////////////////////////
  // Reset release

  logic rst_meta;
  logic rst_sync_n;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync_n <= rst_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Shared per-channel terms

  dcbs_pkg::dcbs_chan_s chan [dcbs_pkg::NCH];
  dcbs_pkg::dcbs_chan_s next_chan [dcbs_pkg::NCH];
  dcbs_pkg::dcbs_state_e state;
  dcbs_pkg::dcbs_state_e next_state;
  logic [1:0] cur;
  logic [1:0] next_cur;
  logic [3:0] run;
  logic [3:0] elig;
  logic [3:0] irq_d;
  logic [1:0] full;
  logic [1:0] pin_ch;
  logic [1:0] pin_fire;
  logic bus_busy;
  logic ev_rd_done;
  logic ev_wr_done;
  logic blk_last;
  logic xfer_last;

  for (genvar p = 0; p < dcbs_pkg::NPIN; p++) begin : g_pair
    assign full[p] = chan[2 * p].ctrl.full;
    // The pin serves the B channel in short mode and the merged channel in full mode
    assign pin_ch[p] = full[p] ? 1'b0 : 1'b1;
  end

  for (genvar g = 0; g < dcbs_pkg::NCH; g++) begin : g_chan
    if (g % 2 == 0) begin : g_a
      assign run[g] = chan[g].ctrl.xfer_enable &
                      (!full[g / 2] | chan[g].ctrl.master_enable);
      assign irq_d[g] = !chan[g].ctrl.xfer_enable & chan[g].ctrl.end_irq_enable;
    end else begin : g_b
      assign run[g] = chan[g].ctrl.xfer_enable & !full[g / 2];
      assign irq_d[g] = !chan[g].ctrl.xfer_enable & chan[g].ctrl.end_irq_enable &
                        !full[g / 2];
    end
    assign elig[g] = chan[g].pend & run[g];
  end

  assign bus_busy = (state == dcbs_pkg::S_DEAD) || (state == dcbs_pkg::S_READ) ||
                    (state == dcbs_pkg::S_WRITE);
  assign ev_rd_done = (state == dcbs_pkg::S_READ) && cyc_done;
  assign ev_wr_done = (state == dcbs_pkg::S_WRITE) && cyc_done;
  assign blk_last = chan[cur].ctrl.block && (chan[cur].blk_cnt == dcbs_pkg::BLK_ONE);
  assign xfer_last = chan[cur].ctrl.block ? blk_last : (chan[cur].count == dcbs_pkg::COUNT_ONE);

  ////////////////////////////////////////////////////////////////////////////////
  // Request pin sampling

  logic [1:0] pin_prev;
  logic [1:0] samp_en;
  logic [1:0] dly_busy;
  logic [2:0] dly_cnt [dcbs_pkg::NPIN];
  logic [1:0] next_pin_prev;
  logic [1:0] next_samp_en;
  logic [1:0] next_dly_busy;
  logic [2:0] next_dly_cnt [dcbs_pkg::NPIN];

  always_comb begin
    logic [1:0] ch;
    logic ext_src;
    logic detect;
    ch = 2'h0;
    ext_src = 1'b0;
    detect = 1'b0;
    for (int p = 0; p < dcbs_pkg::NPIN; p++) begin
      ch = {p[0], pin_ch[p]};
      ext_src = (chan[ch].ctrl.src == dcbs_pkg::SRC_EDGE) ||
                (chan[ch].ctrl.src == dcbs_pkg::SRC_LEVEL);
      next_pin_prev[p] = dma_request_n[p];
      next_samp_en[p] = samp_en[p];
      next_dly_busy[p] = dly_busy[p];
      next_dly_cnt[p] = dly_cnt[p];
      pin_fire[p] = 1'b0;
      detect = samp_en[p] && !dma_request_n[p] &&
               ((chan[ch].ctrl.src == dcbs_pkg::SRC_LEVEL) || pin_prev[p]);
      if (dly_busy[p]) begin
        next_dly_cnt[p] = dly_cnt[p] + dcbs_pkg::DLY_ONE;
        if (dly_cnt[p] == dcbs_pkg::PIN_MIN_STATES) begin
          pin_fire[p] = 1'b1;
          next_dly_busy[p] = 1'b0;
        end
      end else if (detect && ext_src && run[ch]) begin
        next_dly_busy[p] = 1'b1;
        next_dly_cnt[p] = dcbs_pkg::DLY_ONE;
        next_samp_en[p] = 1'b0;
      end
      if (bus_busy && (cur == ch)) begin
        if (ev_rd_done && !chan[ch].ctrl.block) begin
          next_samp_en[p] = 1'b1;
        end
        if (ev_wr_done && blk_last) begin
          next_samp_en[p] = 1'b1;
        end
      end
      if (!run[ch] || !ext_src || standby) begin
        next_samp_en[p] = 1'b1;
        next_dly_busy[p] = 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      pin_prev <= 2'h3;
      samp_en <= 2'h3;
      dly_busy <= 2'h0;
      for (int p = 0; p < dcbs_pkg::NPIN; p++) begin
        dly_cnt[p] <= 3'h0;
      end
    end else begin
      pin_prev <= next_pin_prev;
      samp_en <= next_samp_en;
      dly_busy <= next_dly_busy;
      for (int p = 0; p < dcbs_pkg::NPIN; p++) begin
        dly_cnt[p] <= next_dly_cnt[p];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Bus sequencer

  dcbs_pkg::dcbs_cyc_s next_cyc;
  logic next_bus_req;
  logic [1:0] next_transfer_end_n_n;

  always_comb begin
    logic [1:0] pick;
    logic yield;
    logic higher;
    logic nmi_hit;
    logic hold_mode;
    logic [3:0] hp_mask;
    pick = 2'h0;
    for (int c = dcbs_pkg::NCH - 1; c >= 0; c--) begin
      if (elig[c]) begin
        pick = c[1:0];
      end
    end
    hp_mask = 4'((4'h1 << cur) - 4'h1);
    higher = |(elig & hp_mask);
    yield = !ext_bus_request_n || refresh_req;
    nmi_hit = nmi && full[cur[1]];
    hold_mode = chan[cur].ctrl.block ||
                ((chan[cur].ctrl.src == dcbs_pkg::SRC_AUTO) && chan[cur].ctrl.burst);
    next_state = state;
    next_cur = cur;
    case (state)
      dcbs_pkg::S_IDLE: begin
        if (|elig) begin
          next_state = dcbs_pkg::S_REQ;
        end
      end
      dcbs_pkg::S_REQ: begin
        if (!(|elig)) begin
          next_state = dcbs_pkg::S_IDLE;
        end else if (bus_grant) begin
          next_cur = pick;
          next_state = dcbs_pkg::S_DEAD;
        end
      end
      dcbs_pkg::S_DEAD: begin
        // A channel halted while waiting for the bus costs only this dead state
        next_state = run[cur] ? dcbs_pkg::S_READ : dcbs_pkg::S_REL;
      end
      dcbs_pkg::S_READ: begin
        if (cyc_done) begin
          next_state = dcbs_pkg::S_WRITE;
        end
      end
      dcbs_pkg::S_WRITE: begin
        if (cyc_done) begin
          if (hold_mode && run[cur] && !nmi_hit && !xfer_last && !yield && !higher) begin
            next_state = dcbs_pkg::S_READ;
          end else begin
            next_state = dcbs_pkg::S_REL;
          end
        end
      end
      default: begin
        next_state = dcbs_pkg::S_IDLE;
      end
    endcase
    if (standby) begin
      next_state = dcbs_pkg::S_IDLE;
    end
    next_bus_req = (next_state == dcbs_pkg::S_REQ) || (next_state == dcbs_pkg::S_DEAD) ||
                   (next_state == dcbs_pkg::S_READ) || (next_state == dcbs_pkg::S_WRITE);
    next_cyc.chan = next_cur;
    next_cyc.dead = next_state == dcbs_pkg::S_DEAD;
    next_cyc.rd = next_state == dcbs_pkg::S_READ;
    next_cyc.wr = next_state == dcbs_pkg::S_WRITE;
    next_transfer_end_n_n = 2'h3;
    if ((next_state == dcbs_pkg::S_WRITE) &&
        ((chan[next_cur].ctrl.src == dcbs_pkg::SRC_EDGE) ||
         (chan[next_cur].ctrl.src == dcbs_pkg::SRC_LEVEL)) && xfer_last) begin
      next_transfer_end_n_n[next_cur[1]] = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state <= dcbs_pkg::S_IDLE;
      cur <= 2'h0;
      bus_req <= 1'b0;
      cyc <= dcbs_pkg::CYC_IDLE;
      transfer_end_n <= 2'h3;
    end else begin
      state <= next_state;
      cur <= next_cur;
      bus_req <= next_bus_req;
      cyc <= next_cyc;
      transfer_end_n <= next_transfer_end_n_n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Channel registers, counters, pending requests and register port

  logic [15:0] next_rdata;

  always_comb begin
    logic wr_hit;
    logic mine;
    logic pin_hit;
    wr_hit = 1'b0;
    mine = 1'b0;
    pin_hit = 1'b0;
    for (int c = 0; c < dcbs_pkg::NCH; c++) begin
      next_chan[c] = chan[c];
      mine = ev_wr_done && (cur == c[1:0]);
      pin_hit = pin_fire[c / 2] && (pin_ch[c / 2] == c[0]);
      if (mine) begin
        if (chan[c].ctrl.block) begin
          next_chan[c].blk_cnt = chan[c].blk_cnt - dcbs_pkg::BLK_ONE;
          if (blk_last) begin
            next_chan[c].blk_cnt = chan[c].blk_init;
            next_chan[c].count = chan[c].count - dcbs_pkg::COUNT_ONE;
            next_chan[c].pend = 1'b0;
            if (chan[c].count == dcbs_pkg::COUNT_ONE) begin
              next_chan[c].ctrl.xfer_enable = 1'b0;
            end
          end
        end else begin
          next_chan[c].count = chan[c].count - dcbs_pkg::COUNT_ONE;
          next_chan[c].pend = 1'b0;
          if (chan[c].count == dcbs_pkg::COUNT_ONE) begin
            next_chan[c].ctrl.xfer_enable = 1'b0;
          end
        end
      end
      // Writes are refused while the sequencer owns the bus for a transfer
      wr_hit = reg_wr && !bus_busy && !reg_addr[4] && (reg_addr[3:2] == c[1:0]);
      if (wr_hit) begin
        // Each register part is an independent access; software updates only halted channels
        if (reg_addr[1:0] == dcbs_pkg::SUB_CTRL) begin
          next_chan[c].ctrl = dcbs_pkg::dcbs_ctrl_s'(reg_wdata[7:0]);
        end else if (reg_addr[1:0] == dcbs_pkg::SUB_COUNT) begin
          next_chan[c].count = reg_wdata;
        end else if (reg_addr[1:0] == dcbs_pkg::SUB_BLOCK) begin
          next_chan[c].blk_init = reg_wdata[7:0];
          next_chan[c].blk_cnt = reg_wdata[7:0];
        end
      end
      if ((c % 2 == 0) && nmi && full[c / 2]) begin
        next_chan[c].ctrl.master_enable = 1'b0;
      end
      if (!run[c]) begin
        next_chan[c].pend = 1'b0;
      end else begin
        // Sets come last so a request in the clearing cycle is kept
        if (chan[c].ctrl.src == dcbs_pkg::SRC_AUTO) begin
          next_chan[c].pend = 1'b1;
        end
        if ((chan[c].ctrl.src == dcbs_pkg::SRC_PERIPH) && periph_req[c]) begin
          next_chan[c].pend = 1'b1;
        end
        if (pin_hit) begin
          next_chan[c].pend = 1'b1;
        end
      end
      if (standby) begin
        next_chan[c] = dcbs_pkg::CHAN_RESET;
      end
    end
    next_rdata = dcbs_pkg::RDATA_ZERO;
    if (reg_rd && !bus_busy) begin
      if (reg_addr == dcbs_pkg::ADDR_STATUS) begin
        next_rdata = {1'b0, state, samp_en, cur, run, elig};
      end else if (!reg_addr[4]) begin
        if (reg_addr[1:0] == dcbs_pkg::SUB_CTRL) begin
          next_rdata = {8'h00, chan[reg_addr[3:2]].ctrl};
        end else if (reg_addr[1:0] == dcbs_pkg::SUB_COUNT) begin
          next_rdata = chan[reg_addr[3:2]].count;
        end else if (reg_addr[1:0] == dcbs_pkg::SUB_BLOCK) begin
          next_rdata = {chan[reg_addr[3:2]].blk_cnt, chan[reg_addr[3:2]].blk_init};
        end
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      for (int c = 0; c < dcbs_pkg::NCH; c++) begin
        chan[c] <= dcbs_pkg::CHAN_RESET;
      end
      reg_rdata <= dcbs_pkg::RDATA_ZERO;
      end_irq_ch0a <= 1'b0;
      end_irq_ch0b <= 1'b0;
      end_irq_ch1a <= 1'b0;
      end_irq_ch1b <= 1'b0;
    end else begin
      for (int c = 0; c < dcbs_pkg::NCH; c++) begin
        chan[c] <= next_chan[c];
      end
      reg_rdata <= next_rdata;
      // Interrupt levels follow the enables one cycle later
      end_irq_ch0a <= irq_d[0];
      end_irq_ch0b <= irq_d[1];
      end_irq_ch1a <= irq_d[2];
      end_irq_ch1b <= irq_d[3];
    end
  end

endmodule

// ==== tb/dcbs_asserts.sv ====
// Port assertions of the DMA channel bus sequencer and their bind
`timescale 1ns/10ps
module dcbs_asserts (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic ext_bus_request_n,
  input wire logic refresh_req,
  input wire logic standby,
  input wire logic bus_grant,
  input wire logic cyc_done,
  input wire logic bus_req,
  input wire dcbs_pkg::dcbs_cyc_s cyc,
  input wire logic [1:0] transfer_end_n
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  logic busy;
  assign busy = cyc.dead | cyc.rd | cyc.wr;
  ////////////////////////////////////////////////////////////////////////////////
  a_dead_single: assert property (cyc.dead |=> !cyc.dead && !cyc.wr)
    else $error("dead state not single");
  a_write_follows: assert property ($rose(cyc.wr) |-> $past(cyc.rd))
    else $error("write without read");
  a_pair_kept: assert property (cyc.rd && cyc_done |=> cyc.wr && $stable(cyc.chan))
    else $error("read not paired with write");
  a_bus_held: assert property (busy |-> bus_req)
    else $error("bus cycle without bus request");
  a_grant_first: assert property ($rose(cyc.dead) |-> $past(bus_req && bus_grant))
    else $error("dead state before grant");
  a_yield_bus: assert property (cyc.wr && cyc_done && (!ext_bus_request_n || refresh_req)
      |=> !bus_req && !busy)
    else $error("bus kept against other master");
  a_standby_halt: assert property (standby |=> !bus_req && !busy)
    else $error("standby did not halt");
  a_end_in_write: assert property ((transfer_end_n != 2'h3) |-> cyc.wr)
    else $error("transfer end outside write");
  a_busy_read: assert property (reg_rd && busy |=> reg_rdata == 16'h0000)
    else $error("register read during bus cycle");
endmodule

bind dcbs_top dcbs_asserts u_dcbs_asserts (.core_clk, .rst_n, .reg_rd, .reg_rdata,
  .ext_bus_request_n, .refresh_req, .standby, .bus_grant, .cyc_done, .bus_req, .cyc,
  .transfer_end_n);

// ==== tb/dcbs_bus_ctrl_model.sv ====
// Bus controller model: grants the bus on request and ends each read or write cycle
`timescale 1ns/10ps
module dcbs_bus_ctrl_model (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic bus_req,
  input wire dcbs_pkg::dcbs_cyc_s cyc,
  input wire logic [1:0] wait_states,
  output logic bus_grant,
  output logic cyc_done
);
  logic [1:0] gcnt;
  logic [1:0] wcnt;
  // Grant and cycle end both lag by wait_states, so slow arbitration is exercised too
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      gcnt <= 2'h0;
      wcnt <= 2'h0;
      bus_grant <= 1'b0;
      cyc_done <= 1'b0;
    end else begin
      // Grant falls one cycle after the request, so a released bus is really gone
      bus_grant <= bus_req && (gcnt >= wait_states);
      gcnt <= !bus_req ? 2'h0 : (gcnt == 2'h3 ? gcnt : gcnt + 2'h1);
      if ((cyc.rd || cyc.wr) && !cyc_done) begin
        cyc_done <= (wcnt == wait_states);
        wcnt <= wcnt + 2'h1;
      end else begin
        cyc_done <= 1'b0;
        wcnt <= 2'h0;
      end
    end
  end
endmodule

// ==== tb/tb_dma_channel_bus_sequencer.sv ====
// Self-checking bench for the DMA channel bus sequencer
`timescale 1ns/10ps
module tb_dma_channel_bus_sequencer;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [4:0] reg_addr = 5'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [3:0] periph_req = 4'h0;
  logic [1:0] dma_request_n = 2'h3;
  logic ext_bus_request_n = 1'b1;
  logic refresh_req = 1'b0;
  logic nmi = 1'b0;
  logic standby = 1'b0;
  logic [1:0] ws = 2'h0;
  logic [15:0] reg_rdata;
  logic bus_grant, cyc_done, bus_req;
  dcbs_pkg::dcbs_cyc_s cyc;
  logic [1:0] transfer_end_n;
  logic [3:0] irq;
  int fails = 0;
  int tests_run = 0;
  int deads = 0;
  int tends = 0;
  int seen[$];
  int exp_q[$];
  logic [31:0] seed = 32'h6877;

  always #50 core_clk = ~core_clk;

  dcbs_top DUT (.core_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .periph_req, .dma_request_n, .ext_bus_request_n, .refresh_req, .nmi, .standby,
    .bus_grant, .cyc_done, .bus_req, .cyc, .transfer_end_n, .end_irq_ch0a(irq[0]),
    .end_irq_ch0b(irq[1]), .end_irq_ch1a(irq[2]), .end_irq_ch1b(irq[3]));

  dcbs_bus_ctrl_model u_bus (.core_clk, .rst_n, .bus_req, .cyc, .wait_states(ws),
    .bus_grant, .cyc_done);

  // Reference record of every completed unit, taken from the bus cycle signals
  always @(posedge core_clk) begin
    if (cyc.dead === 1'b1) deads++;
    if (cyc.wr === 1'b1 && cyc_done === 1'b1) begin
      seen.push_back(int'(cyc.chan));
      if (transfer_end_n !== 2'h3) tends++;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  task automatic give_verdict();
    if (fails == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic chk_val(input string what, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic chk_seq(input string what);
    tests_run++;
    if (seen != exp_q) begin
      fails++;
      $display("CHECK FAILED %s expected %p seen %p", what, exp_q, seen);
    end
    seen = {};
  endtask

  task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [4:0] a, output logic [15:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic setup(input logic [1:0] c, input logic [15:0] ctl, input logic [15:0] cnt);
    wr_reg({1'b0, c, 2'h1}, cnt);
    wr_reg({1'b0, c, 2'h0}, ctl);
  endtask

  // Bounded waits: a hang counts as a mismatch and ends the run
  task automatic wait_units(input int n, input int tail);
    int k;
    k = 0;
    while (seen.size() < n && k < 2000) begin
      @(posedge core_clk);
      k++;
    end
    if (k >= 2000) begin
      fails++;
      give_verdict();
    end
    repeat (tail) @(posedge core_clk);
  endtask

  task automatic wait_rd();
    int k;
    k = 0;
    while (cyc.rd !== 1'b1 && k < 500) begin
      @(posedge core_clk);
      k++;
    end
    if (k >= 500) begin
      fails++;
      give_verdict();
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [15:0] v;
    logic [7:0] cm [4];
    logic [3:0] e;
    int gap;
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    chk_val("bus_req", 16'h0, {15'h0, bus_req});
    chk_val("transfer_end_n", 16'h3, {14'h0, transfer_end_n});
    rd_reg(5'h00, v);
    chk_val("ctrl after reset", 16'h0, v);
    rd_reg(5'h1f, v);
    chk_val("unmapped read", 16'h0, v);
    // Random control values with the channel halted: end interrupts follow the enables
    for (int r = 0; r < 6; r++) begin
      for (int c = 0; c < 4; c++) begin
        seed = lfsr(seed);
        cm[c] = seed[7:0] & 8'hfe;
        e[c] = cm[c][2] & ~(c[0] & cm[c & 2][7]);
        wr_reg({1'b0, 2'(c), 2'h0}, {8'h00, cm[c]});
      end
      for (int c = 0; c < 4; c++) begin
        rd_reg({1'b0, 2'(c), 2'h0}, v);
        chk_val("ctrl readback", {8'h00, cm[c]}, v);
      end
      chk_val("end irq", {12'h0, e}, {12'h0, irq});
    end
    for (int c = 0; c < 4; c++) wr_reg({1'b0, 2'(c), 2'h0}, 16'h0000);
    // All four channels at once, with an nmi that short mode must ignore
    ws <= 2'h2;
    for (int c = 3; c >= 0; c--) setup(2'(c), 16'h0005, 16'h0001);
    @(posedge core_clk);
    periph_req <= 4'hf;
    nmi <= 1'b1;
    @(posedge core_clk);
    periph_req <= 4'h0;
    nmi <= 1'b0;
    exp_q = {0, 1, 2, 3};
    wait_units(4, 6);
    chk_seq("priority order");
    chk_val("dead per unit", 16'h4, 16'(deads));
    chk_val("end irq all", 16'hf, {12'h0, irq});
    // The end pin belongs to pin-started transfers only, so peripheral units leave it high
    chk_val("transfer_end_n count", 16'h0, 16'(tends));
    // Level request on the pin of pair 0 held low for three units
    ws <= 2'h0;
    setup(2'h1, 16'h0011, 16'h0003);
    @(posedge core_clk);
    dma_request_n[0] <= 1'b0;
    gap = 0;
    while (cyc.dead !== 1'b1 && gap < 100) begin
      @(posedge core_clk);
      gap++;
    end
    if (gap >= 100) begin
      fails++;
      give_verdict();
    end
    chk_val("pin to transfer gap", 16'h1, {15'h0, gap >= 5});
    exp_q = {1, 1, 1};
    wait_units(3, 6);
    dma_request_n[0] <= 1'b1;
    chk_seq("level request");
    // Block mode: an edge in mid-block is not seen, one block per edge
    deads = 0;
    tends = 0;
    ws <= 2'h2;
    wr_reg(5'h02, 16'h0002);
    setup(2'h0, 16'h00cb, 16'h0002);
    @(posedge core_clk);
    dma_request_n[0] <= 1'b0;
    wait_rd();
    dma_request_n[0] <= 1'b1;
    @(posedge core_clk);
    dma_request_n[0] <= 1'b0;
    exp_q = {0, 0};
    wait_units(2, 26);
    chk_seq("one block per edge");
    dma_request_n[0] <= 1'b1;
    @(posedge core_clk);
    dma_request_n[0] <= 1'b0;
    wait_units(2, 6);
    dma_request_n[0] <= 1'b1;
    chk_seq("second block");
    chk_val("block transfer_end_n", 16'h2, 16'(tends));
    chk_val("block dead", 16'h2, 16'(deads));
    rd_reg(5'h00, v);
    chk_val("blocks done", 16'h00ca, v);
    // Full mode burst stopped by nmi, then resumed and interrupted by other masters
    setup(2'h2, 16'h00bb, 16'h0004);
    wait_rd();
    nmi <= 1'b1;
    @(posedge core_clk);
    nmi <= 1'b0;
    rd_reg(5'h10, v);
    chk_val("read while busy", 16'h0, v);
    exp_q = {2};
    wait_units(1, 30);
    chk_seq("nmi stop");
    rd_reg(5'h08, v);
    chk_val("nmi master enable", 16'h00b9, v);
    deads = 0;
    ws <= 2'h1;
    wr_reg(5'h08, 16'h00bb);
    wait_rd();
    refresh_req <= 1'b1;
    ext_bus_request_n <= 1'b0;
    wait_units(1, 0);
    refresh_req <= 1'b0;
    ext_bus_request_n <= 1'b1;
    exp_q = {2, 2, 2};
    wait_units(3, 6);
    chk_seq("resume after nmi");
    chk_val("yield dead", 16'h2, 16'(deads));
    rd_reg(5'h08, v);
    chk_val("burst done", 16'h00ba, v);
    // Standby in mid-transfer clears and halts the channel
    setup(2'h0, 16'h0019, 16'h0008);
    wait_rd();
    standby <= 1'b1;
    @(posedge core_clk);
    standby <= 1'b0;
    repeat (20) @(posedge core_clk);
    rd_reg(5'h00, v);
    chk_val("standby ctrl", 16'h0, v);
    rd_reg(5'h01, v);
    chk_val("standby count", 16'h0, v);
    give_verdict();
  end
endmodule
